// ### src/ssll_pkg.sv
package ssll_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned SHIFT_W = 224;
  localparam int unsigned LATCH_W = 218;
  localparam int unsigned CMD_W   = 6;
  localparam int unsigned PWM_W   = 16;
  localparam int unsigned BS_W    = 7;
  localparam int unsigned CNT_W   = 15;
  localparam int unsigned THR_W   = 18;

  // Write command held in the top bits of the shift register
  localparam logic [CMD_W-1:0] CMD_WRITE = 6'h25;

  // ----------------------------------------------------------------
  // Latch field positions (lsb of each field)
  // ----------------------------------------------------------------
  localparam int unsigned PWM_LSB0   = 0;    // red0, then green0, blue0, red1 ...
  localparam int unsigned BS_RED_LSB = 192;
  localparam int unsigned BS_GRN_LSB = 199;
  localparam int unsigned BS_BLU_LSB = 206;
  localparam int unsigned BLANK_BIT  = 213;
  localparam int unsigned REPEAT_BIT = 214;
  localparam int unsigned RESYNC_BIT = 215;
  localparam int unsigned EXTCLK_BIT = 216;
  localparam int unsigned EDGE_BIT   = 217;
  localparam logic        BLANK_RST  = 1'b1;

  // ----------------------------------------------------------------
  // Timing: the core clock stands in for the internal oscillator
  // ----------------------------------------------------------------
  localparam int unsigned CORE_PERIOD_NS  = 100;
  localparam int unsigned OSC_PERIOD_NS   = 100;
  localparam int unsigned IDLE_MULT       = 8;
  localparam int unsigned TIMEOUT_MIN_OSC = 8;
  localparam int unsigned TIMEOUT_MAX_OSC = 16384;
  localparam int unsigned TIMEOUT_MIN_CYC =
    (TIMEOUT_MIN_OSC * OSC_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned TIMEOUT_MAX_CYC =
    (TIMEOUT_MAX_OSC * OSC_PERIOD_NS) / CORE_PERIOD_NS;

  // Idle watcher states
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_ARMED = 1'b1
  } ssll_state_t;

endpackage : ssll_pkg

// ### src/ssll_loader.sv
`timescale 1ns/1ns

// How it works
// - A 224-bit shift register takes the serial data pin on the serial clock.
// - Each serial clock rising edge shifts all bits up by one and loads the data pin at bit 0.
// - Bit 0 of the shift register is fed from the serial data input pin.
// - The serial data output pin follows the shift register msb at all times.
// - The six msbs are the write command and only 100101b allows a latch update.
// - A latch pulse with command 25h copies the 218 low shift bits into the latch.
// - A latch pulse with any other command leaves the latch unchanged.
// - The shift register has no reset and holds whatever was shifted in.
// - Only the blank bit 213 of the latch is set to 1 at reset; the rest is not reset.
// - Latch bits 47-0 give the red, green, blue 16-bit levels of group 0.
// - Groups 1 and 2 and group 3 red follow at bits 159-48 in the same order.
// - Bits 191-160 give group 3 green and blue; bits 212-192 give three 7-bit scales.
// - Bits 213-217 are blank, auto repeat, timing reset, external clock, edge select.
// - The latch pulse fires after 8x the last serial clock interval with no edge.
// - The idle timeout is clamped between 8 and 16384 oscillator periods.
module ssll_loader
  import ssll_pkg::*;
#(
  parameter int unsigned TIMEOUT_MAX = TIMEOUT_MAX_CYC
) (
  // Core clock and reset
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  // Serial link pins
  input  wire logic               serialClockInPin,
  input  wire logic               serialDataInPin,
  output logic                    serialDataOutPin,
  // Latch update strobe
  output logic                    latchStrobe,
  // PWM levels
  output logic [PWM_W-1:0]        red0PwmLevel,
  output logic [PWM_W-1:0]        green0PwmLevel,
  output logic [PWM_W-1:0]        blue0PwmLevel,
  output logic [PWM_W-1:0]        red1PwmLevel,
  output logic [PWM_W-1:0]        green1PwmLevel,
  output logic [PWM_W-1:0]        blue1PwmLevel,
  output logic [PWM_W-1:0]        red2PwmLevel,
  output logic [PWM_W-1:0]        green2PwmLevel,
  output logic [PWM_W-1:0]        blue2PwmLevel,
  output logic [PWM_W-1:0]        red3PwmLevel,
  output logic [PWM_W-1:0]        green3PwmLevel,
  output logic [PWM_W-1:0]        blue3PwmLevel,
  // Brightness scales
  output logic [BS_W-1:0]         redBrightnessScale,
  output logic [BS_W-1:0]         greenBrightnessScale,
  output logic [BS_W-1:0]         blueBrightnessScale,
  // Function control
  output logic                    outputBlank,
  output logic                    autoRepeatEnable,
  output logic                    timingResetOnLatch,
  output logic                    externalPwmClockSelect,
  output logic                    outputEdgeSelect
);

  localparam logic [CNT_W-1:0] MaxCnt  = CNT_W'(TIMEOUT_MAX);
  localparam logic [THR_W-1:0] MinThr  = THR_W'(TIMEOUT_MIN_CYC);
  localparam logic [THR_W-1:0] MaxThr  = THR_W'(TIMEOUT_MAX);
  localparam logic [THR_W-1:0] MultThr = THR_W'(IDLE_MULT);

  // ----------------------------------------------------------------
  // Link domain: shift register
  // ----------------------------------------------------------------
  logic [SHIFT_W-1:0] shift_q;
  logic               edgeTgl_q;
  logic [1:0]         linkEdges_q;

  // No reset on purpose: contents are whatever was last shifted in
  always_ff @(posedge serialClockInPin) begin
    shift_q <= {shift_q[SHIFT_W-2:0], serialDataInPin};
  end

  // Msb drives the cascade output
  assign serialDataOutPin = shift_q[SHIFT_W-1];

  // One toggle per edge tells the core domain that a bit arrived
  always_ff @(posedge serialClockInPin or negedge arst_n) begin
    if (!arst_n) begin
      edgeTgl_q <= 1'b0;
    end else begin
      edgeTgl_q <= ~edgeTgl_q;
    end
  end

  // Edge count, used only to qualify checks on the unreset register
  always_ff @(posedge serialClockInPin or negedge arst_n) begin
    if (!arst_n) begin
      linkEdges_q <= 2'h0;
    end else if (linkEdges_q != 2'h3) begin
      linkEdges_q <= linkEdges_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: edge synchroniser
  // ----------------------------------------------------------------
  logic edgeSync1_q;
  logic edgeSync2_q;
  logic edgeSync3_q;
  logic bitEdge;

  // Toggle passes two flops before the edge detector looks at it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      edgeSync1_q <= 1'b0;
      edgeSync2_q <= 1'b0;
      edgeSync3_q <= 1'b0;
    end else begin
      edgeSync1_q <= edgeTgl_q;
      edgeSync2_q <= edgeSync1_q;
      edgeSync3_q <= edgeSync2_q;
    end
  end

  assign bitEdge = edgeSync2_q ^ edgeSync3_q;

  // ----------------------------------------------------------------
  // Core domain: interval measurement and idle timeout
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] idleCnt_q;
  logic [CNT_W-1:0] lastPeriod_q;
  logic [THR_W-1:0] thresh;
  logic             fire;
  logic             cmdOk;
  ssll_state_t      state_q;

  // Time since the last edge; saturates so a long pause stays bounded
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      idleCnt_q <= '0;
    end else if (bitEdge) begin
      idleCnt_q <= '0;
    end else if (idleCnt_q != MaxCnt) begin
      idleCnt_q <= idleCnt_q + CNT_W'(1);
    end
  end

  // Interval between the last two edges
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lastPeriod_q <= MaxCnt;
    end else if (bitEdge) begin
      lastPeriod_q <= idleCnt_q;
    end
  end

  // Timeout is 8x the interval, clamped to the oscillator limits
  always_comb begin
    thresh = THR_W'(lastPeriod_q) * MultThr;
    if (thresh < MinThr) begin
      thresh = MinThr;
    end else if (thresh > MaxThr) begin
      thresh = MaxThr;
    end
  end

  // Command is read only while the link clock is idle, so the bits are still
  assign cmdOk = (shift_q[SHIFT_W-1 -: CMD_W] == CMD_WRITE);

  // A fresh edge wins over a timeout landing in the same cycle
  assign fire = (state_q == ST_ARMED) && !bitEdge &&
                (THR_W'(idleCnt_q) == thresh);

  // Armed by every edge, disarmed once the timeout has fired
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (bitEdge) begin
            state_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (fire) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Strobe only for a matching command
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      latchStrobe <= 1'b0;
    end else begin
      latchStrobe <= fire && cmdOk;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: control data latch
  // ----------------------------------------------------------------
  logic [BLANK_BIT-1:0]         latchLow_q;
  logic                         blank_q;
  logic [LATCH_W-1:BLANK_BIT+1] latchHigh_q;
  logic                         loaded_q;

  // Data fields carry no reset; all bits load in the same edge
  always_ff @(posedge core_clk) begin
    if (fire && cmdOk) begin
      latchLow_q  <= shift_q[BLANK_BIT-1:0];
      latchHigh_q <= shift_q[LATCH_W-1:BLANK_BIT+1];
    end
  end

  // Blank comes up set so outputs stay off until data is valid
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      blank_q <= BLANK_RST;
    end else if (fire && cmdOk) begin
      blank_q <= shift_q[BLANK_BIT];
    end
  end

  // Marks the first load, used only to qualify checks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      loaded_q <= 1'b0;
    end else if (fire && cmdOk) begin
      loaded_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  localparam int unsigned NumLevels = 12;
  logic [NumLevels-1:0][PWM_W-1:0] pwmLevel;

  // Twelve 16-bit levels, red, green, blue per group
  for (genvar i = 0; i < NumLevels; i++) begin : g_pwm
    assign pwmLevel[i] = latchLow_q[PWM_LSB0 + i*PWM_W +: PWM_W];
  end

  assign red0PwmLevel   = pwmLevel[0];
  assign green0PwmLevel = pwmLevel[1];
  assign blue0PwmLevel  = pwmLevel[2];
  assign red1PwmLevel   = pwmLevel[3];
  assign green1PwmLevel = pwmLevel[4];
  assign blue1PwmLevel  = pwmLevel[5];
  assign red2PwmLevel   = pwmLevel[6];
  assign green2PwmLevel = pwmLevel[7];
  assign blue2PwmLevel  = pwmLevel[8];
  assign red3PwmLevel   = pwmLevel[9];
  assign green3PwmLevel = pwmLevel[10];
  assign blue3PwmLevel  = pwmLevel[11];

  // Brightness scales and function bits
  assign redBrightnessScale     = latchLow_q[BS_RED_LSB +: BS_W];
  assign greenBrightnessScale   = latchLow_q[BS_GRN_LSB +: BS_W];
  assign blueBrightnessScale    = latchLow_q[BS_BLU_LSB +: BS_W];
  assign outputBlank            = blank_q;
  assign autoRepeatEnable       = latchHigh_q[REPEAT_BIT];
  assign timingResetOnLatch     = latchHigh_q[RESYNC_BIT];
  assign externalPwmClockSelect = latchHigh_q[EXTCLK_BIT];
  assign outputEdgeSelect       = latchHigh_q[EDGE_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_lsb_entry: assert property (@(posedge serialClockInPin) disable iff (!arst_n)
    linkEdges_q != 2'h0 |-> shift_q[0] == $past(serialDataInPin))
    else $error("Serial input not loaded at bit 0");

  a_shift_step: assert property (@(posedge serialClockInPin) disable iff (!arst_n)
    linkEdges_q == 2'h3 |-> shift_q[1] == $past(shift_q[0]))
    else $error("Shift register did not move up one place");

  a_latch_load: assert property (@(posedge core_clk) disable iff (!arst_n)
    fire && cmdOk |=> {latchHigh_q, blank_q, latchLow_q} == $past(shift_q[LATCH_W-1:0]))
    else $error("Latch did not take the shift register");

  a_latch_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    loaded_q && !(fire && cmdOk) |=> $stable({latchHigh_q, blank_q, latchLow_q}))
    else $error("Latch changed without a qualified pulse");

  a_strobe_cmd: assert property (@(posedge core_clk) disable iff (!arst_n)
    latchStrobe |-> $past(fire) && $past(cmdOk))
    else $error("Strobe without matching command");

  a_strobe_width: assert property (@(posedge core_clk) disable iff (!arst_n)
    latchStrobe |=> !latchStrobe)
    else $error("Strobe longer than one cycle");

  a_timeout_mult: assert property (@(posedge core_clk) disable iff (!arst_n)
    fire |-> THR_W'(idleCnt_q) >= THR_W'(lastPeriod_q) * MultThr || thresh == MaxThr)
    else $error("Timeout shorter than 8x the interval");

  a_timeout_min: assert property (@(posedge core_clk) disable iff (!arst_n)
    fire |-> THR_W'(idleCnt_q) >= MinThr)
    else $error("Timeout below the minimum");

  // The pulse must not slip past the cap, even if counter and cap disagree in width
  a_timeout_max: assert property (@(posedge core_clk) disable iff (!arst_n)
    state_q == ST_ARMED && !bitEdge && THR_W'(idleCnt_q) == MaxThr |-> fire)
    else $error("Timeout beyond the maximum");

  c_good_load: cover property (@(posedge core_clk) disable iff (!arst_n)
    latchStrobe ##1 !outputBlank);
  c_bad_cmd: cover property (@(posedge core_clk) disable iff (!arst_n)
    fire && !cmdOk);
  c_max_clamp: cover property (@(posedge core_clk) disable iff (!arst_n)
    fire && thresh == MaxThr);

endmodule : ssll_loader

// ### testbench/ssll_ctrl_model.sv
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Serial controller model: 32 ns link clock, msb first frames
// ------------------------------------------------------------------
module ssll_ctrl_model (
  // Serial link pins driven toward the loader
  output logic serialClockInPin,
  output logic serialDataInPin
);
  // Link clock stands low between frames
  initial begin
    serialClockInPin = 1'b0;
    serialDataInPin  = 1'b0;
  end

  // Send the low n bits of a word, msb first; data settles half a period before rising
  task automatic send(input logic [223:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serialDataInPin = bits[i];
      #16 serialClockInPin = 1'b1;
      #16 serialClockInPin = 1'b0;
    end
    // Released line shows no stale bit, so a late sample cannot pass by luck
    serialDataInPin = ~serialDataInPin;
  endtask : send
endmodule : ssll_ctrl_model

// ### testbench/tb_serial_shift_latch_loader.sv
`timescale 1ns/1ns

// ------------------------------------------------------------------
// Bench for the serial shift and latch loader
// ------------------------------------------------------------------
module tb_serial_shift_latch_loader;
  import ssll_pkg::*;
  logic                   core_clk;
  logic                   arst_n;
  logic                   serialClockInPin;
  logic                   serialDataInPin;
  logic                   serialDataOutPin;
  logic                   latchStrobe;
  logic [11:0][PWM_W-1:0] pwm;
  logic [2:0][BS_W-1:0]   bs;
  logic [4:0]             ctl;
  int                     num_errors = 0;
  int                     num_checks = 0;
  logic [223:0]           fA, fB, fC;
  logic [5:0]             badCmd [4] = '{6'h24, 6'h05, 6'h3F, 6'h1A};

  // Small timeout cap keeps the slow-link case short
  ssll_loader #(.TIMEOUT_MAX(64)) dut (
    .core_clk(core_clk), .arst_n(arst_n),
    .serialClockInPin(serialClockInPin), .serialDataInPin(serialDataInPin),
    .serialDataOutPin(serialDataOutPin), .latchStrobe(latchStrobe),
    .red0PwmLevel(pwm[0]), .green0PwmLevel(pwm[1]), .blue0PwmLevel(pwm[2]),
    .red1PwmLevel(pwm[3]), .green1PwmLevel(pwm[4]), .blue1PwmLevel(pwm[5]),
    .red2PwmLevel(pwm[6]), .green2PwmLevel(pwm[7]), .blue2PwmLevel(pwm[8]),
    .red3PwmLevel(pwm[9]), .green3PwmLevel(pwm[10]), .blue3PwmLevel(pwm[11]),
    .redBrightnessScale(bs[0]), .greenBrightnessScale(bs[1]),
    .blueBrightnessScale(bs[2]), .outputBlank(ctl[0]), .autoRepeatEnable(ctl[1]),
    .timingResetOnLatch(ctl[2]), .externalPwmClockSelect(ctl[3]),
    .outputEdgeSelect(ctl[4])
  );

  ssll_ctrl_model link (
    .serialClockInPin(serialClockInPin),
    .serialDataInPin(serialDataInPin)
  );

  // Core clock, 100 ns
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Compare one value, count it, report a mismatch at once
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Frame: command, then 218 latch bits with distinct field contents
  function automatic logic [223:0] mkFrame(input logic [5:0] cmd, input logic [4:0] fcv,
                                           input logic [15:0] base);
    logic [217:0] l;
    for (int i = 0; i < 12; i++) l[i*16 +: 16] = base + 16'(i * 16'h0111);
    l[212:192] = {base[6:0], ~base[6:0], base[13:7]};
    l[217:213] = fcv;
    return {cmd, l};
  endfunction : mkFrame

  // Every latch output against the frame that should sit in the latch
  task automatic chkLatch(input logic [223:0] f);
    for (int i = 0; i < 12; i++) chk(pwm[i], f[i*16 +: 16], "pwm level");
    chk(bs[0], f[198:192], "red scale");
    chk(bs[1], f[205:199], "green scale");
    chk(bs[2], f[212:206], "blue scale");
    chk(ctl, f[217:213], "function bits");
  endtask : chkLatch

  // Shift a frame, then wait a bounded time for the latch strobe
  task automatic sendWait(input logic [223:0] f, input bit split, input bit expS,
                          input int lo, input int hi, input logic [223:0] expL);
    int  n;
    logic got;
    @(posedge core_clk);
    #7;
    if (split) begin
      link.send(f >> 1, 223);
      #2000;
      link.send(f, 1);
    end else begin
      link.send(f, 224);
    end
    chk(serialDataOutPin, f[223], "data out msb");
    n = 0;
    got = 1'b0;
    while (n < 100 && !got) begin
      @(negedge core_clk);
      n++;
      got = (latchStrobe === 1'b1);
    end
    chk(got, expS, "strobe seen");
    if (expS) chk(n >= lo && n <= hi, 1'b1, "strobe delay");
    chkLatch(expL);
    @(negedge core_clk);
    chk(latchStrobe, 1'b0, "strobe one cycle");
  endtask : sendWait

  // Watchdog: tests need well under 300 us
  initial begin
    #1000000;
    num_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(negedge core_clk);
    chk(ctl[0], BLANK_RST, "blank after reset");
    chk(latchStrobe, 1'b0, "strobe after reset");
    $display("test reset done");
    // Load levels with blank still set before anything clears it
    fA = mkFrame(CMD_WRITE, 5'b01011, 16'h1234);
    sendWait(fA, 1'b0, 1'b1, 8, 16, fA);
    $display("test load done");
    foreach (badCmd[k]) begin
      fB = mkFrame(badCmd[k], 5'b10100, 16'hBEEF);
      sendWait(fB, 1'b0, 1'b0, 0, 0, fA);
    end
    $display("test refused done");
    // Slow last bit: interval times eight exceeds the cap, so the cap rules
    fC = mkFrame(CMD_WRITE, 5'b10110, 16'hC0DE);
    sendWait(fC, 1'b1, 1'b1, 64, 72, fC);
    $display("test slow link done");
    fB = mkFrame(CMD_WRITE, 5'b01001, 16'h0F0F);
    sendWait(fB, 1'b0, 1'b1, 8, 16, fB);
    $display("test reload done");
    tally_and_finish();
  end
endmodule : tb_serial_shift_latch_loader
